// [core/sgr_pkg.sv]
package sgr_pkg;

  // Bus widths shared by both host ports and the internal system bus, except the processor port's 32-bit address.
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam int PAR_W = 4;
  localparam int REG_W = 8;
  localparam int BYTE_W = 8;

  // Global register addresses on the 18-bit system address bus.
  localparam logic [17:0] ADDR_CLK_SEL = 18'h30A00;
  localparam logic [17:0] ADDR_THR_LO = 18'h30A01;
  localparam logic [17:0] ADDR_THR_HI = 18'h30A02;
  localparam logic [17:0] ADDR_STATUS = 18'h30A03;

  // Region prefixes: 256-byte regions use address [17:8], the global one [17:4].
  localparam int REGION_HI = 17;
  localparam int REGION_LO = 8;
  localparam int GLOBAL_LO = 4;
  localparam logic [9:0] REGION_SERDES_A = 10'h300;
  localparam logic [9:0] REGION_SERDES_B = 10'h301;
  localparam logic [9:0] REGION_CHAN_A = 10'h308;
  localparam logic [9:0] REGION_CHAN_B = 10'h309;
  localparam logic [13:0] REGION_GLOBAL = 14'h30A0;

  // Clock select fields: four 2-bit fields, quad A tx, quad A rx, quad B tx, quad B rx.
  localparam int CKS_FIELDS = 4;
  localparam int CKS_FIELD_W = 2;
  localparam logic [1:0] SEL_CODE_C = 2'h2;
  localparam logic [1:0] SEL_CODE_D = 2'h3;

  // Threshold fields and the resync control bit.
  localparam int THR_W = 5;
  localparam int THR_LO_POS = 5;
  localparam int THR_LO_W = 3;
  localparam int THR_HI_POS = 0;
  localparam int THR_HI_W = 2;
  localparam int RESYNC_POS = 2;

  // Status bit positions.
  localparam int OVFL_POS = 0;
  localparam int FAIL_POS = 1;

  // Reset values.
  localparam logic [7:0] CLK_SEL_RST = 8'h00;
  localparam logic [2:0] THR_LO_RST = 3'h0;
  localparam logic [1:0] THR_HI_RST = 2'h0;

  localparam logic PORT_PROC = 1'b0;
  localparam logic PORT_FABRIC = 1'b1;

  typedef enum logic [1:0] {
    SRC_DEFAULT,
    SRC_CHAN_C,
    SRC_CHAN_D
  } sgr_src_t;

  typedef enum logic [2:0] {
    RGN_NONE,
    RGN_SERDES_A,
    RGN_SERDES_B,
    RGN_CHAN_A,
    RGN_CHAN_B,
    RGN_GLOBAL
  } sgr_region_t;

  typedef struct packed {
    logic port;
    logic write;
    logic [17:0] addr;
    logic [31:0] wdata;
    logic [3:0] wpar;
  } sgr_req_t;

  typedef struct packed {
    logic [31:0] rdata;
    logic [3:0] rpar;
    logic err;
  } sgr_resp_t;

  // One parity bit per byte lane; odd selects odd parity.
  function automatic logic [3:0] sgr_parity(input logic [31:0] d, input logic odd);
    logic [3:0] p;
    p = '0;
    for (int i = 0; i < PAR_W; i++) begin
      p[i] = (^d[i*BYTE_W +: BYTE_W]) ^ odd;
    end
    return p;
  endfunction

endpackage

// [core/sgr_sync.sv]
`timescale 1ns/1ps

// Two-stage synchroniser for level inputs from outside the register clock.
module sgr_sync #(
  parameter int WIDTH = 2
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // The first stage feeds only the second stage.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule // sgr_sync

// [core/sgr_port_arb.sv]
`timescale 1ns/1ps

// Takes one request at a time from the two host ports and maps both onto the system address.
module sgr_port_arb (
  input wire logic mclk,
  input wire logic rst,
  input wire logic proc_req,
  input wire logic proc_write,
  input wire logic [0:31] proc_addr,
  input wire logic [31:0] proc_wdata,
  input wire logic [3:0] proc_wpar,
  input wire logic fab_req,
  input wire logic fab_write,
  input wire logic [17:0] fab_addr,
  input wire logic [31:0] fab_wdata,
  input wire logic [3:0] fab_wpar,
  input wire logic done,
  output logic req_valid,
  output sgr_pkg::sgr_req_t req
);
  import sgr_pkg::*;

  typedef enum logic [1:0] {
    ARB_IDLE,
    ARB_BUSY,
    ARB_GAP
  } sgr_arb_state_t;

  sgr_arb_state_t state;

  // One gap cycle after each answer lets the host drop its request before a new grant.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= ARB_IDLE;
    end else begin
      unique case (state)
        ARB_IDLE: if (proc_req || fab_req) state <= ARB_BUSY;
        ARB_BUSY: if (done) state <= ARB_GAP;
        ARB_GAP: state <= ARB_IDLE;
        default: state <= ARB_IDLE;
      endcase
    end
  end

  // The processor port wins a tie; its MSb-first bits 14..31 are system bits 17..0.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      req <= '0;
      req_valid <= 1'b0;
    end else begin
      req_valid <= (state == ARB_IDLE) && (proc_req || fab_req);
      if (state == ARB_IDLE && proc_req) begin
        req <= '{port: PORT_PROC, write: proc_write, addr: proc_addr[14:31],
                 wdata: proc_wdata, wpar: proc_wpar};
      end else if (state == ARB_IDLE && fab_req) begin
        req <= '{port: PORT_FABRIC, write: fab_write, addr: fab_addr,
                 wdata: fab_wdata, wpar: fab_wpar};
      end
    end
  end

endmodule // sgr_port_arb

// [core/sgr_global_regs.sv]
`timescale 1ns/1ps

module sgr_global_regs #(
  parameter logic ODD_PARITY = 1'b0,
  parameter int EXT_TIMEOUT_CYC = 64
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic processor_port_req,
  input wire logic processor_port_write,
  input wire logic [0:31] processor_port_address,
  input wire logic [31:0] processor_port_wdata,
  input wire logic [3:0] processor_port_wpar,
  output logic processor_port_ack,
  output sgr_pkg::sgr_resp_t processor_port_resp,
  input wire logic fabric_master_req,
  input wire logic fabric_master_write,
  input wire logic [17:0] fabric_master_address,
  input wire logic [31:0] fabric_master_wdata,
  input wire logic [3:0] fabric_master_wpar,
  output logic fabric_master_ack,
  output sgr_pkg::sgr_resp_t fabric_master_resp,
  output logic ext_req,
  output sgr_pkg::sgr_region_t ext_region,
  output logic ext_write,
  output logic [17:0] ext_addr,
  output logic [31:0] ext_wdata,
  output logic [3:0] ext_wpar,
  input wire logic ext_ack,
  input wire logic [31:0] ext_rdata,
  input wire logic [3:0] ext_rpar,
  input wire logic align_overflow_in,
  input wire logic align_fail_in,
  output sgr_pkg::sgr_src_t quad_a_tx_clock_source,
  output sgr_pkg::sgr_src_t quad_a_rx_clock_source,
  output sgr_pkg::sgr_src_t quad_b_tx_clock_source,
  output sgr_pkg::sgr_src_t quad_b_rx_clock_source,
  output logic [4:0] rx_fifo_low_threshold,
  output logic group_resync_request
);
  import sgr_pkg::*;

  localparam int TMO_W = $clog2(EXT_TIMEOUT_CYC + 1);
  localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(EXT_TIMEOUT_CYC - 1);

  typedef enum logic {
    ST_IDLE,
    ST_EXT
  } sgr_state_t;

  sgr_state_t state;
  sgr_req_t req;
  logic req_valid;
  logic done;
  logic [1:0] align_sync;
  logic [7:0] clk_sel;
  logic [2:0] thr_lo;
  logic [1:0] thr_hi;
  logic resync_ctl;
  logic resync_prev;
  logic ovfl;
  logic fail;
  logic [TMO_W-1:0] tmo_cnt;
  sgr_region_t region;
  logic par_ok;
  logic local_take;
  logic ext_take;
  logic ext_end;
  logic ext_timeout;
  logic wr_ok;
  logic hit_clk;
  logic hit_lo;
  logic hit_hi;
  logic hit_stat;
  logic status_rd;
  logic [7:0] rd_byte;
  logic next_fire;
  sgr_resp_t next_resp;
  sgr_src_t src_q [CKS_FIELDS];

  // Both ports arrive here already folded onto one 18-bit system address.
  sgr_port_arb u_arb (
    .mclk(mclk),
    .rst(rst),
    .proc_req(processor_port_req),
    .proc_write(processor_port_write),
    .proc_addr(processor_port_address),
    .proc_wdata(processor_port_wdata),
    .proc_wpar(processor_port_wpar),
    .fab_req(fabric_master_req),
    .fab_write(fabric_master_write),
    .fab_addr(fabric_master_address),
    .fab_wdata(fabric_master_wdata),
    .fab_wpar(fabric_master_wpar),
    .done(done),
    .req_valid(req_valid),
    .req(req)
  );

  // Alignment events come from the transceiver clock, so they are synchronised first.
  sgr_sync #(
    .WIDTH(2)
  ) u_sync (
    .mclk(mclk),
    .rst(rst),
    .async_in({align_fail_in, align_overflow_in}),
    .sync_out(align_sync)
  );

  // Region decode on the 18-bit system address.
  always_comb begin
    region = RGN_NONE;
    if (req.addr[REGION_HI:GLOBAL_LO] == REGION_GLOBAL) begin
      region = RGN_GLOBAL;
    end else if (req.addr[REGION_HI:REGION_LO] == REGION_SERDES_A) begin
      region = RGN_SERDES_A;
    end else if (req.addr[REGION_HI:REGION_LO] == REGION_SERDES_B) begin
      region = RGN_SERDES_B;
    end else if (req.addr[REGION_HI:REGION_LO] == REGION_CHAN_A) begin
      region = RGN_CHAN_A;
    end else if (req.addr[REGION_HI:REGION_LO] == REGION_CHAN_B) begin
      region = RGN_CHAN_B;
    end
  end

  // Global register hits and the conditions under which a request is served here.
  assign hit_clk = (req.addr == ADDR_CLK_SEL);
  assign hit_lo = (req.addr == ADDR_THR_LO);
  assign hit_hi = (req.addr == ADDR_THR_HI);
  assign hit_stat = (req.addr == ADDR_STATUS);
  assign par_ok = (sgr_parity(req.wdata, ODD_PARITY) == req.wpar);
  assign ext_take = (state == ST_IDLE) && req_valid && (region != RGN_GLOBAL)
                    && (region != RGN_NONE);
  assign local_take = (state == ST_IDLE) && req_valid && !ext_take;
  assign wr_ok = local_take && req.write && par_ok;
  assign status_rd = local_take && !req.write && hit_stat;
  assign ext_timeout = (state == ST_EXT) && (tmo_cnt == TMO_LAST);
  assign ext_end = (state == ST_EXT) && (ext_ack || ext_timeout);
  assign done = processor_port_ack || fabric_master_ack;

  // Read data of the addressed global register; reserved bits read as zero.
  always_comb begin
    rd_byte = '0;
    if (hit_clk) begin
      rd_byte = clk_sel;
    end else if (hit_lo) begin
      rd_byte[THR_LO_POS +: THR_LO_W] = thr_lo;
    end else if (hit_hi) begin
      rd_byte[THR_HI_POS +: THR_HI_W] = thr_hi;
      rd_byte[RESYNC_POS] = resync_ctl;
    end else if (hit_stat) begin
      rd_byte[OVFL_POS] = ovfl;
      rd_byte[FAIL_POS] = fail;
    end
  end

  // Answer for whichever request finishes this cycle.
  always_comb begin
    next_fire = local_take || ext_end;
    next_resp = '0;
    if (local_take) begin
      next_resp.rdata = {{(DATA_W - REG_W){1'b0}}, rd_byte};
      next_resp.err = (region == RGN_NONE) || !(hit_clk || hit_lo || hit_hi || hit_stat)
                      || (req.write && !par_ok);
      if (req.write || next_resp.err) begin
        next_resp.rdata = '0;
      end
      next_resp.rpar = sgr_parity(next_resp.rdata, ODD_PARITY);
    end else if (ext_end) begin
      next_resp.rdata = ext_timeout ? '0 : ext_rdata;
      next_resp.rpar = ext_timeout ? sgr_parity('0, ODD_PARITY) : ext_rpar;
      next_resp.err = ext_timeout && !ext_ack;
    end
  end

  // Local answers take one cycle; forwarded ones wait for the region owner.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: if (ext_take) state <= ST_EXT;
        ST_EXT: if (ext_end) state <= ST_IDLE;
      endcase
    end
  end

  // Forwarded access to the per-quad SERDES and channel blocks, held until answered.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ext_req <= 1'b0;
      ext_region <= RGN_NONE;
      ext_write <= 1'b0;
      ext_addr <= '0;
      ext_wdata <= '0;
      ext_wpar <= '0;
    end else if (ext_take) begin
      ext_req <= 1'b1;
      ext_region <= region;
      ext_write <= req.write;
      ext_addr <= req.addr;
      ext_wdata <= req.wdata;
      ext_wpar <= req.wpar;
    end else if (ext_end) begin
      ext_req <= 1'b0;
    end
  end

  // A silent region owner would otherwise lock both host ports forever.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tmo_cnt <= '0;
    end else if (state == ST_EXT && !ext_end) begin
      tmo_cnt <= tmo_cnt + 1'b1;
    end else begin
      tmo_cnt <= '0;
    end
  end

  // The answer goes back only to the port that was granted.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      processor_port_ack <= 1'b0;
      fabric_master_ack <= 1'b0;
      processor_port_resp <= '0;
      fabric_master_resp <= '0;
    end else begin
      processor_port_ack <= next_fire && (req.port == PORT_PROC);
      fabric_master_ack <= next_fire && (req.port == PORT_FABRIC);
      if (next_fire && req.port == PORT_PROC) begin
        processor_port_resp <= next_resp;
      end
      if (next_fire && req.port == PORT_FABRIC) begin
        fabric_master_resp <= next_resp;
      end
    end
  end

  // Clock source select register, one byte of four 2-bit fields.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      clk_sel <= CLK_SEL_RST;
    end else if (wr_ok && hit_clk) begin
      clk_sel <= req.wdata[REG_W-1:0];
    end
  end

  // Threshold registers; values above 17 are stored as written, so software must keep them in range.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      thr_lo <= THR_LO_RST;
      thr_hi <= THR_HI_RST;
    end else begin
      if (wr_ok && hit_lo) begin
        thr_lo <= req.wdata[THR_LO_POS +: THR_LO_W];
      end
      if (wr_ok && hit_hi) begin
        thr_hi <= req.wdata[THR_HI_POS +: THR_HI_W];
      end
    end
  end

  // Resync control bit shares the threshold-high register.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      resync_ctl <= 1'b0;
    end else if (wr_ok && hit_hi) begin
      resync_ctl <= req.wdata[RESYNC_POS];
    end
  end

  // Rewriting 1 over 1 is no edge, so a second resync needs a 0 written first.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      resync_prev <= 1'b0;
      group_resync_request <= 1'b0;
    end else begin
      resync_prev <= resync_ctl;
      group_resync_request <= resync_ctl && !resync_prev;
    end
  end

  // Sticky status; a new event in the clearing read's cycle still sets the bit.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ovfl <= 1'b0;
      fail <= 1'b0;
    end else begin
      ovfl <= align_sync[OVFL_POS] || (ovfl && !status_rd);
      fail <= align_sync[FAIL_POS] || (fail && !status_rd);
    end
  end

  // Each 2-bit field picks channel C or D; other codes leave the quad's own default.
  for (genvar i = 0; i < CKS_FIELDS; i++) begin : g_cks
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        src_q[i] <= SRC_DEFAULT;
      end else if (clk_sel[i*CKS_FIELD_W +: CKS_FIELD_W] == SEL_CODE_C) begin
        src_q[i] <= SRC_CHAN_C;
      end else if (clk_sel[i*CKS_FIELD_W +: CKS_FIELD_W] == SEL_CODE_D) begin
        src_q[i] <= SRC_CHAN_D;
      end else begin
        src_q[i] <= SRC_DEFAULT;
      end
    end
  end

  // Threshold output assembled from both registers, high bits on top.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_fifo_low_threshold <= '0;
    end else begin
      rx_fifo_low_threshold <= {thr_hi, thr_lo};
    end
  end

  // The source outputs come straight from the per-field flip-flops, so they never glitch.
  assign quad_a_tx_clock_source = src_q[0];
  assign quad_a_rx_clock_source = src_q[1];
  assign quad_b_tx_clock_source = src_q[2];
  assign quad_b_rx_clock_source = src_q[3];

endmodule // sgr_global_regs

// [verification/sgr_global_regs_sva.sv]
`timescale 1ns/1ps

// Timing relations between host answers, the link and the control outputs.
module sgr_global_regs_sva
  import sgr_pkg::*;
#(
  parameter int EXT_TIMEOUT_CYC = 64
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic processor_port_req,
  input wire logic processor_port_ack,
  input wire logic fabric_master_ack,
  input wire logic ext_req,
  input wire logic ext_ack,
  input wire logic [17:0] ext_addr,
  input wire sgr_pkg::sgr_region_t ext_region,
  input wire sgr_pkg::sgr_src_t quad_a_tx_clock_source,
  input wire sgr_pkg::sgr_src_t quad_b_rx_clock_source,
  input wire logic [4:0] rx_fifo_low_threshold,
  input wire logic group_resync_request
);
  localparam int TMO_B = EXT_TIMEOUT_CYC + 4;
  localparam int ANS_B = 2 * EXT_TIMEOUT_CYC + 16;
  logic any_ack;

  // Either port answering; the controls may only move after an answer.
  assign any_ack = processor_port_ack | fabric_master_ack;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // An owner acknowledge closes the link access and answers the host next cycle.
  sequence ext_done_s;
    ext_req && ext_ack;
  endsequence
  sequence host_ans_s;
    !ext_req && any_ack;
  endsequence

  proc_ack_pulse_a: assert property (processor_port_ack |=> !processor_port_ack)
    else $error("processor ack too long");
  fab_ack_pulse_a: assert property (fabric_master_ack |=> !fabric_master_ack)
    else $error("fabric ack too long");
  one_answer_a: assert property (!(processor_port_ack && fabric_master_ack))
    else $error("both ports answered");
  ext_answer_a: assert property (ext_done_s |=> host_ans_s)
    else $error("link answer not passed on");
  ext_hold_a: assert property (ext_req && !ext_ack ##1 ext_req |-> $stable(ext_addr))
    else $error("link address moved");
  region_map_a: assert property (ext_req |->
    (ext_region == RGN_CHAN_B) == (ext_addr[17:8] == REGION_CHAN_B) &&
    (ext_region == RGN_SERDES_A) == (ext_addr[17:8] == REGION_SERDES_A))
    else $error("link region wrong");
  ext_bound_a: assert property ($rose(ext_req) |-> ##[1:TMO_B] !ext_req)
    else $error("link access never ended");
  proc_answer_a: assert property (
    $rose(processor_port_req) |-> ##[2:ANS_B] processor_port_ack)
    else $error("processor request unanswered");
  ctrl_quiet_a: assert property (!any_ack |=> $stable(quad_a_tx_clock_source) &&
    $stable(quad_b_rx_clock_source) && $stable(rx_fifo_low_threshold))
    else $error("control changed without access");
  resync_pulse_a: assert property (group_resync_request |=> !group_resync_request)
    else $error("resync longer than one cycle");
  resync_cause_a: assert property (group_resync_request |->
    $past(any_ack, 1) || $past(any_ack, 2) || $past(any_ack, 3))
    else $error("resync without write");
endmodule // sgr_global_regs_sva

bind sgr_global_regs sgr_global_regs_sva #(.EXT_TIMEOUT_CYC(EXT_TIMEOUT_CYC)) i_sva (
  .mclk(mclk),
  .rst(rst),
  .processor_port_req(processor_port_req),
  .processor_port_ack(processor_port_ack),
  .fabric_master_ack(fabric_master_ack),
  .ext_req(ext_req),
  .ext_ack(ext_ack),
  .ext_addr(ext_addr),
  .ext_region(ext_region),
  .quad_a_tx_clock_source(quad_a_tx_clock_source),
  .quad_b_rx_clock_source(quad_b_rx_clock_source),
  .rx_fifo_low_threshold(rx_fifo_low_threshold),
  .group_resync_request(group_resync_request)
);

// [verification/sgr_ext_model.sv]
`timescale 1ns/1ps

// Owner of the serdes and channel regions; answers after a set delay or never.
module sgr_ext_model
  import sgr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] delay,
  input wire logic mute,
  input wire logic ext_req,
  input wire logic [17:0] ext_addr,
  output logic ext_ack,
  output logic [31:0] ext_rdata,
  output logic [3:0] ext_rpar
);
  logic [3:0] cnt;
  logic [31:0] word;

  // Each location answers with a word built from its own address.
  assign word = {~ext_addr[13:0], ext_addr};

  // Outside the answer cycle the data lines flip, so stale data never looks valid.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt <= 4'h0;
      ext_ack <= 1'b0;
      ext_rdata <= 32'h0;
      ext_rpar <= 4'h0;
    end else begin
      ext_ack <= 1'b0;
      ext_rdata <= ~ext_rdata;
      ext_rpar <= ~ext_rpar;
      cnt <= (ext_req && !ext_ack) ? cnt + 4'h1 : 4'h0;
      if (ext_req && !ext_ack && cnt == delay && !mute) begin
        ext_ack <= 1'b1;
        ext_rdata <= word;
        for (int i = 0; i < 4; i++) begin
          ext_rpar[i] <= ^word[i*8 +: 8];
        end
      end
    end
  end
endmodule // sgr_ext_model

// [verification/serdes_global_register_bank_tb.sv]
`timescale 1ns/1ps

// Drives both host ports against a mirror of the register file.
module serdes_global_register_bank_tb;
  import sgr_pkg::*;
  localparam int TMO = 8;
  logic mclk = 1'b0, rst = 1'b1, p_req = 1'b0, p_wr = 1'b0, f_req = 1'b0, f_wr = 1'b0;
  logic [0:31] p_addr = 32'h0;
  logic [17:0] f_addr = 18'h0;
  logic [31:0] p_wd = 32'h0, f_wd = 32'h0;
  logic [3:0] p_wp = 4'h0, f_wp = 4'h0, dly = 4'h0;
  logic ovf = 1'b0, fail = 1'b0, mute = 1'b0;
  logic p_ack, f_ack, e_req, e_wr, e_ack, rsy, e;
  sgr_resp_t p_resp, f_resp;
  sgr_region_t e_rgn;
  logic [17:0] e_addr;
  logic [31:0] e_wd, e_rd, r;
  logic [3:0] e_wp, e_rp;
  sgr_src_t s_atx, s_arx, s_btx, s_brx;
  logic [4:0] thr;
  int seed = 82710, error_cnt = 0, check_count = 0, cyc = 0, pulses = 0, exp_pulses = 0;
  int mreg[3] = '{0, 0, 0};
  int rgn_q[$] = '{'h30000, 'h30100, 'h30800, 'h30900};

  sgr_global_regs #(.ODD_PARITY(1'b0), .EXT_TIMEOUT_CYC(TMO)) i_dut (
    .mclk(mclk), .rst(rst),
    .processor_port_req(p_req), .processor_port_write(p_wr), .processor_port_address(p_addr),
    .processor_port_wdata(p_wd), .processor_port_wpar(p_wp),
    .processor_port_ack(p_ack), .processor_port_resp(p_resp),
    .fabric_master_req(f_req), .fabric_master_write(f_wr), .fabric_master_address(f_addr),
    .fabric_master_wdata(f_wd), .fabric_master_wpar(f_wp),
    .fabric_master_ack(f_ack), .fabric_master_resp(f_resp),
    .ext_req(e_req), .ext_region(e_rgn), .ext_write(e_wr), .ext_addr(e_addr),
    .ext_wdata(e_wd), .ext_wpar(e_wp), .ext_ack(e_ack), .ext_rdata(e_rd), .ext_rpar(e_rp),
    .align_overflow_in(ovf), .align_fail_in(fail),
    .quad_a_tx_clock_source(s_atx), .quad_a_rx_clock_source(s_arx),
    .quad_b_tx_clock_source(s_btx), .quad_b_rx_clock_source(s_brx),
    .rx_fifo_low_threshold(thr), .group_resync_request(rsy));

  sgr_ext_model i_ext (.mclk(mclk), .rst(rst), .delay(dly), .mute(mute), .ext_req(e_req),
    .ext_addr(e_addr), .ext_ack(e_ack), .ext_rdata(e_rd), .ext_rpar(e_rp));

  // Free-running clock; a cycle ceiling cuts a hang short.
  always #50 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (rsy === 1'b1) pulses++;
    if (cyc == 20000) begin
      error_cnt++;
      test_done();
    end
  end

  function automatic logic [3:0] par(input logic [31:0] d);
    for (int i = 0; i < 4; i++) par[i] = ^d[i*8 +: 8];
  endfunction

  function automatic sgr_src_t src(input int f);
    case ((mreg[0] >> (2 * f)) & 3)
      2: return SRC_CHAN_C;
      3: return SRC_CHAN_D;
      default: return SRC_DEFAULT;
    endcase
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One host access: held until the acknowledge is sampled, then released.
  task automatic acc(input logic fab, input logic wr, input logic [17:0] a,
      input logic [31:0] d, input logic [3:0] pp, output logic [31:0] rd, output logic er);
    int n;
    @(posedge mclk);
    #1;
    if (fab) {f_req, f_wr, f_addr, f_wd, f_wp} = {1'b1, wr, a, d, pp};
    else {p_req, p_wr, p_addr, p_wd, p_wp} = {1'b1, wr, 14'h0, a, d, pp};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while ((fab ? f_ack : p_ack) !== 1'b1 && n < 100);
    {rd, er} = fab ? {f_resp.rdata, f_resp.err} : {p_resp.rdata, p_resp.err};
    chk(32'(n < 100), 32'h1, "no answer");
    #1;
    p_req = 1'b0;
    f_req = 1'b0;
  endtask

  task automatic rreg(input logic fab, input logic [17:0] a, input logic [31:0] x,
      input logic xe);
    acc(fab, 1'b0, a, 32'h0, 4'h0, r, e);
    chk(r, x, "read data");
    chk({31'h0, e}, {31'h0, xe}, "read err");
    chk({28'h0, fab ? f_resp.rpar : p_resp.rpar}, {28'h0, par(r)}, "read parity");
  endtask

  // The mirror keeps only the defined bits; a rising resync bit expects one pulse.
  task automatic put(input logic fab, input int i, input logic [31:0] d);
    acc(fab, 1'b1, 18'(ADDR_CLK_SEL + i), d, par(d), r, e);
    chk({31'h0, e}, 32'h0, "write err");
    if (i == 2 && !mreg[2][2] && d[2]) exp_pulses++;
    mreg[i] = d & ((i == 0) ? 32'hFF : (i == 1) ? 32'hE0 : 32'h07);
  endtask

  task automatic chk_out();
    chk({30'h0, s_atx}, {30'h0, src(0)}, "a tx source");
    chk({30'h0, s_arx}, {30'h0, src(1)}, "a rx source");
    chk({30'h0, s_btx}, {30'h0, src(2)}, "b tx source");
    chk({30'h0, s_brx}, {30'h0, src(3)}, "b rx source");
    chk({27'h0, thr}, ((mreg[2] & 3) << 3) | (mreg[1] >> 5), "threshold");
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    logic [31:0] d;
    int t;
    repeat (5) @(posedge mclk);
    #1;
    rst = 1'b0;
    for (int i = 0; i < 4; i++) rreg(i[0], 18'(ADDR_CLK_SEL + i), 0, 0);
    chk_out();
    $display("test reset done");
    // Every field code, threshold bounds, readback through the same or the other port.
    for (int k = 0; k < 8; k++) begin
      d = $random(seed);
      if (k < 4) d[7:0] = {4{k[1:0]}};
      put(k[0], 0, d);
      t = (k == 0) ? 17 : (k == 1) ? 0 : {$random(seed)} % 18;
      d = $random(seed);
      put(k[1], 1, {d[31:8], t[2:0], d[4:0]});
      d = $random(seed);
      put(!k[0], 2, {d[31:3], 1'b0, t[4:3]});
      for (int i = 0; i < 3; i++) rreg(k[1] ^ i[0], 18'(ADDR_CLK_SEL + i), mreg[i], 0);
      chk_out();
    end
    $display("test config done");
    for (int j = 0; j < 4; j++) put(j[0], 2, (mreg[2] & 3) | ((j != 2) ? 4 : 0));
    repeat (4) @(posedge mclk);
    chk(pulses, exp_pulses, "resync pulses");
    $display("test resync done");
    for (int v = 1; v < 4; v++) begin
      @(posedge mclk);
      #1;
      {fail, ovf} = 2'(v);
      repeat (2) @(posedge mclk);
      #1;
      {fail, ovf} = 2'b00;
      repeat (5) @(posedge mclk);
      rreg(v[1], ADDR_STATUS, v, 0);
      rreg(!v[1], ADDR_STATUS, 0, 0);
    end
    acc(1'b1, 1'b1, ADDR_STATUS, 32'hFF, par(32'hFF), r, e);
    chk({31'h0, e}, 32'h0, "status write err");
    rreg(1'b0, ADDR_STATUS, 0, 0);
    $display("test status done");
    rreg(1'b0, 18'h30A04, 0, 1);
    rreg(1'b1, 18'h30500, 0, 1);
    acc(1'b1, 1'b1, ADDR_CLK_SEL, 32'h5A, ~par(32'h5A), r, e);
    chk({31'h0, e}, 32'h1, "parity err");
    rreg(1'b0, ADDR_CLK_SEL, mreg[0], 0);
    foreach (rgn_q[j]) begin
      dly = 4'({$random(seed)} % 6);
      t = rgn_q[j] + ({$random(seed)} % 256);
      rreg(j[0], 18'(t), {~t[13:0], t[17:0]}, 0);
      chk({29'h0, e_rgn}, 32'(j + 1), "link region");
      d = $random(seed);
      acc(!j[0], 1'b1, 18'(t), d, par(d), r, e);
      chk({31'h0, e}, 32'h0, "link write err");
      chk(e_wd, d, "link write data");
      chk({27'h0, e_wr, e_wp}, {27'h0, 1'b1, par(d)}, "link write parity");
      chk({14'h0, e_addr}, {14'h0, 18'(t)}, "link address");
    end
    mute = 1'b1;
    acc(1'b0, 1'b0, 18'h30104, 32'h0, 4'h0, r, e);
    chk({31'h0, e}, 32'h1, "timeout err");
    $display("test decode done");
    test_done();
  end
endmodule // serdes_global_register_bank_tb
